// ---- design/gpt_pkg.sv ----
// shared constants, modes and configuration carriers for the timer unit
package gpt_pkg;

  // counter geometry
  localparam int TIMER_WIDTH = 16;
  localparam int NUM_TIMERS = 5;
  localparam int NUM_PINS = 11;

  // timer slot positions within the value and config vectors
  localparam int IDX_AUX_A = 0;
  localparam int IDX_CORE = 1;
  localparam int IDX_AUX_B = 2;
  localparam int IDX_PREC = 3;
  localparam int IDX_SEC = 4;

  // pin slot offsets inside the sampled pin vector
  localparam int PIN_CLK_BASE = 0;
  localparam int PIN_DIR_BASE = 5;
  localparam int PIN_CAP = 10;

  // finest resolution in system clock cycles per increment
  localparam int M1_RES_CYCLES = 4;
  localparam int M2_RES_CYCLES = 2;
  localparam logic [15:0] M1_BASE = 16'(M1_RES_CYCLES);
  localparam logic [15:0] M2_BASE = 16'(M2_RES_CYCLES);

  // values after reset, clear value, count limit and unit step
  localparam logic [15:0] VALUE_RST = 16'h0000;
  localparam logic [15:0] PRESC_RST = 16'h0000;
  localparam logic [15:0] CLEAR_VALUE = 16'h0000;
  localparam logic [15:0] MAX_VALUE = 16'hFFFF;
  localparam logic [15:0] ONE = 16'h0001;

  // basic operating modes of a timer
  typedef enum logic [1:0] {
    MODE_TIMER,
    MODE_GATED,
    MODE_COUNTER,
    MODE_ENCODER
  } timer_mode_t;

  // extra role of an auxiliary timer towards the core timer
  typedef enum logic [1:0] {
    ROLE_COUNT,
    ROLE_CAPTURE,
    ROLE_RELOAD
  } aux_role_t;

  // per-timer configuration
  typedef struct packed {
    logic run;             // counting allowed
    timer_mode_t mode;     // operating mode
    logic [2:0] presc;     // prescaler exponent, period = base << presc
    logic [1:0] edge_sel;  // bit0 rising, bit1 falling edge of count/trigger input
    logic gate_pol;        // level that opens the gate in gated mode
    logic clk_tl;          // counter mode counts toggle latch edges, not the pin
    logic dir_down;        // software direction, 1 = down
    logic dir_ext_en;      // direction pin high inverts the software direction
  } tmr_cfg_t;

  // auxiliary timer role configuration
  typedef struct packed {
    aux_role_t role;       // counting, capture or reload
    logic reload_ext;      // reload on a selected edge of its own input pin
    logic reload_tl_rise;  // reload when the core toggle latch goes high
    logic reload_tl_fall;  // reload when the core toggle latch goes low
  } aux_cfg_t;

  // capture/reload register configuration
  typedef struct packed {
    logic [1:0] edge_sel;  // bit0 rising, bit1 falling
    logic src_capture_trigger_input;       // trigger from the capture input pin
    logic src_core_clk;    // trigger from the core clock input
    logic src_core_dir;    // trigger from the core direction input
    logic clear_after;     // clear precision timer after capture
    logic reload_sec;      // reload secondary timer on its wrap
  } cap_cfg_t;

endpackage

// ---- design/pin_sampler.sv ----
// two-flop synchroniser with edge detection for one external pin
`timescale 1ns/1ns
module pin_sampler (
  input logic clk,
  input logic sys_rst,
  input logic pin,
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta_q;  // first stage, read only by the second
  logic sync_q;  // synchronised level
  logic prev_q;  // level one cycle earlier

  // shift the pin through the synchroniser and history stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // edge pulses stand in the cycle the synced level changes
  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

endmodule

// ---- design/timer_cell.sv ----
// one 16-bit up/down timer register with write, load and wrap detection
`timescale 1ns/1ns
module timer_cell (
  input logic clk,
  input logic sys_rst,
  input logic wr_en,
  input logic [15:0] wr_data,
  input logic load,
  input logic [15:0] load_val,
  input logic cnt_en,
  input logic up,
  output logic [15:0] value,
  output logic wrap
);

  logic [15:0] value_q;  // timer contents
  logic [15:0] value_d;  // next contents
  logic [15:0] stepped;  // contents after one count step

  // wraps naturally from FFFF to 0000 up and 0000 to FFFF down [R20]
  assign stepped = up ? 16'(value_q + gpt_pkg::ONE) : 16'(value_q - gpt_pkg::ONE);
  // wrap is flagged even when a load replaces the value [R20]
  assign wrap = cnt_en & (up ? (value_q == gpt_pkg::MAX_VALUE) : (value_q == gpt_pkg::VALUE_RST));
  // hardware load beats software write, write beats counting
  assign value_d = load ? load_val : (wr_en ? wr_data : (cnt_en ? stepped : value_q));

  // timer register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      value_q <= gpt_pkg::VALUE_RST;
    end else begin
      value_q <= value_d;
    end
  end

  assign value = value_q;

endmodule

// ---- design/general_timer_unit.sv ----
// five-timer general purpose timer unit
// Functional notes
// R1 - five 16-bit timers, concatenation within module only
// R2 - first-module timers: timer, gated, counter, encoder
// R3 - timer mode prescaled clock, counter mode pin events
// R4 - gated mode counts only while gate level
// R5 - first module resolution four clock cycles
// R6 - software direction, optionally altered by direction pin
// R7 - encoder phases derive count and direction
// R8 - core toggle latch inverts on wrap, output
// R9 - core toggle latch clocks auxiliary timers
// R10 - capture or reload role stops auxiliary timer
// R11 - capture role latches core value on pin
// R12 - reload role loads core on pin/latch edge
// R13 - opposite latch edge reloads give continuous PWM
// R14 - second module: two timers, register, two cycles
// R15 - second-module timers prescaled or external clocked
// R16 - secondary latch toggles, clocks precision, output
// R17 - secondary wrap exported, reloads from register
// R18 - register captures precision value, optional clear
// R19 - capture also from core clock/direction pins
// R20 - wrap at FFFF/0000 flags overflow/underflow
// R21 - external inputs stable one resolution period
`timescale 1ns/1ns
module general_timer_unit (
  input logic clk,
  input logic sys_rst,
  // slots: aux_timer_a, core_timer, aux_timer_b, precision_timer, secondary_timer
  input logic [4:0] timer_clock_gate_input,
  input logic [4:0] timer_direction_input,
  input logic capture_trigger_input,
  input gpt_pkg::tmr_cfg_t [4:0] tmr_cfg,
  input gpt_pkg::aux_cfg_t aux_a_cfg,
  input gpt_pkg::aux_cfg_t aux_b_cfg,
  input gpt_pkg::cap_cfg_t cap_cfg,
  input logic [4:0] tmr_wr,
  input logic [15:0] tmr_wdata,
  input logic cap_wr,
  input logic [15:0] cap_wdata,
  input logic core_out_en,
  input logic sec_out_en,
  output logic [4:0][15:0] timer_value,
  output logic [15:0] capture_reload_register,
  output logic core_toggle_latch,
  output logic secondary_toggle_latch,
  output logic core_toggle_output,
  output logic secondary_toggle_output,
  output logic secondary_wrap_event
);

  // sampled pins: clock/gate, direction, capture
  logic [10:0] pin_raw;
  logic [10:0] pin_lvl;
  logic [10:0] pin_rise;
  logic [10:0] pin_fall;

  // per-timer control
  logic [4:0] pre_tick;   // prescaler tick for each timer
  logic [4:0] cnt_en;     // timer advances this cycle
  logic [4:0] cnt_up;     // direction of that step
  logic [4:0] load;       // hardware load request
  logic [15:0] load_val [5];
  logic [4:0] wrap;       // overflow or underflow this cycle
  logic [4:0] role_idle;  // timer may count in its basic mode
  logic [4:0] tl_rise_src;  // toggle latch rising edge usable as count source
  logic [4:0] tl_fall_src;  // toggle latch falling edge usable as count source

  // state held in this module
  logic [15:0] presc_cnt_q;  // free-running prescaler base
  logic core_tl_q;           // core toggle latch
  logic sec_tl_q;            // secondary toggle latch
  logic [15:0] cap_q;        // capture/reload register
  logic core_out_q;
  logic sec_out_q;
  logic sec_wrap_q;

  // toggle latch transitions, visible in the cycle of the wrap
  logic core_tl_rise;
  logic core_tl_fall;
  logic sec_tl_rise;
  logic sec_tl_fall;

  // auxiliary role decodes
  logic cap_a_hit;
  logic cap_b_hit;
  logic rel_a_hit;
  logic rel_b_hit;
  logic cap_ev;
  logic aux_a_trig;  // selected edge on the aux_timer_a pin
  logic aux_b_trig;  // selected edge on the aux_timer_b pin

  // selected edge of a rising/falling pair
  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    edge_hit = (sel[0] & r) | (sel[1] & f);
  endfunction

  // count step decision from the basic mode
  function automatic logic mode_tick(
    input gpt_pkg::tmr_cfg_t c,
    input logic pre,
    input logic lvl,
    input logic r,
    input logic f,
    input logic tr,
    input logic tf,
    input logic enc
  );
    logic t;
    t = 1'b0;
    unique case (c.mode)
      // prescaled system clock [R3]
      gpt_pkg::MODE_TIMER: t = pre;
      // prescaled clock only while the gate is open [R4]
      gpt_pkg::MODE_GATED: t = pre & (lvl == c.gate_pol);
      // pin events, or toggle latch edges for concatenation [R3] [R9] [R16]
      gpt_pkg::MODE_COUNTER: t = c.clk_tl ? edge_hit(c.edge_sel, tr, tf)
                                           : edge_hit(c.edge_sel, r, f);
      // any phase edge of the encoder [R7]
      gpt_pkg::MODE_ENCODER: t = enc;
    endcase
    mode_tick = c.run & t;
  endfunction

  // one vector for the synchroniser bank
  assign pin_raw = {capture_trigger_input, timer_direction_input, timer_clock_gate_input};

  // synchronise every external input [R21]
  for (genvar p = 0; p < gpt_pkg::NUM_PINS; p++) begin : g_pin
    pin_sampler u_pin (
      .clk(clk),
      .sys_rst(sys_rst),
      .pin(pin_raw[p]),
      .level(pin_lvl[p]),
      .rise(pin_rise[p]),
      .fall(pin_fall[p])
    );
  end

  // toggle latch transitions occur exactly on a wrap [R8] [R16]
  assign core_tl_rise = wrap[gpt_pkg::IDX_CORE] & ~core_tl_q;
  assign core_tl_fall = wrap[gpt_pkg::IDX_CORE] & core_tl_q;
  assign sec_tl_rise = wrap[gpt_pkg::IDX_SEC] & ~sec_tl_q;
  assign sec_tl_fall = wrap[gpt_pkg::IDX_SEC] & sec_tl_q;

  // aux timers see the core latch, precision the secondary [R1] [R9] [R16]
  assign tl_rise_src = {1'b0, sec_tl_rise, core_tl_rise, 1'b0, core_tl_rise};
  assign tl_fall_src = {1'b0, sec_tl_fall, core_tl_fall, 1'b0, core_tl_fall};

  // auxiliary timers stop while acting as capture or reload registers [R10]
  assign role_idle = {2'b11,
                      aux_b_cfg.role == gpt_pkg::ROLE_COUNT,
                      1'b1,
                      aux_a_cfg.role == gpt_pkg::ROLE_COUNT};

  // per-timer prescaler, mode and direction, then the timer [R1]
  for (genvar i = 0; i < gpt_pkg::NUM_TIMERS; i++) begin : g_tmr
    localparam int CLK_PIN = gpt_pkg::PIN_CLK_BASE + i;
    localparam int DIR_PIN = gpt_pkg::PIN_DIR_BASE + i;
    // first module at four cycles, second at two [R5] [R14]
    localparam logic [15:0] BASE = (i < 3) ? gpt_pkg::M1_BASE : gpt_pkg::M2_BASE;
    // encoder mode only exists in the first module [R2]
    localparam logic HAS_ENC = (i < 3);
    logic [15:0] mask;
    logic enc_ev;
    logic enc_up;
    logic enc_on;

    // programmable prescaler: tick once every BASE << presc cycles [R3] [R15]
    assign mask = 16'((BASE << tmr_cfg[i].presc) - gpt_pkg::ONE);
    assign pre_tick[i] = (presc_cnt_q & mask) == mask;

    // phase A on the clock input, phase B on the direction input [R7]
    assign enc_ev = HAS_ENC & (pin_rise[CLK_PIN] | pin_fall[CLK_PIN] |
                               pin_rise[DIR_PIN] | pin_fall[DIR_PIN]);
    // A edge counts up when A differs from B, B edge when they match [R7]
    assign enc_up = (pin_rise[CLK_PIN] | pin_fall[CLK_PIN]) ?
                    (pin_lvl[CLK_PIN] != pin_lvl[DIR_PIN]) :
                    (pin_lvl[CLK_PIN] == pin_lvl[DIR_PIN]);
    assign enc_on = HAS_ENC & (tmr_cfg[i].mode == gpt_pkg::MODE_ENCODER);

    // count enable from the mode, gated by the auxiliary role [R2] [R10]
    assign cnt_en[i] = role_idle[i] &
                       mode_tick(tmr_cfg[i], pre_tick[i], pin_lvl[CLK_PIN],
                                 pin_rise[CLK_PIN], pin_fall[CLK_PIN],
                                 tl_rise_src[i], tl_fall_src[i], enc_ev);

    // software direction, optionally inverted by the direction pin [R6]
    assign cnt_up[i] = enc_on ? (enc_up ^ tmr_cfg[i].dir_down) :
                       ~(tmr_cfg[i].dir_down ^ (tmr_cfg[i].dir_ext_en & pin_lvl[DIR_PIN]));

    timer_cell u_cell (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr_en(tmr_wr[i]),
      .wr_data(tmr_wdata),
      .load(load[i]),
      .load_val(load_val[i]),
      .cnt_en(cnt_en[i]),
      .up(cnt_up[i]),
      .value(timer_value[i]),
      .wrap(wrap[i])
    );
  end

  // selected edge on each auxiliary pin, shared by capture and reload [R11] [R12]
  assign aux_a_trig = edge_hit(tmr_cfg[gpt_pkg::IDX_AUX_A].edge_sel,
                               pin_rise[gpt_pkg::PIN_CLK_BASE + gpt_pkg::IDX_AUX_A],
                               pin_fall[gpt_pkg::PIN_CLK_BASE + gpt_pkg::IDX_AUX_A]);
  assign aux_b_trig = edge_hit(tmr_cfg[gpt_pkg::IDX_AUX_B].edge_sel,
                               pin_rise[gpt_pkg::PIN_CLK_BASE + gpt_pkg::IDX_AUX_B],
                               pin_fall[gpt_pkg::PIN_CLK_BASE + gpt_pkg::IDX_AUX_B]);

  // capture role: latch the core timer on the auxiliary input edge [R11]
  assign cap_a_hit = (aux_a_cfg.role == gpt_pkg::ROLE_CAPTURE) & aux_a_trig;
  assign cap_b_hit = (aux_b_cfg.role == gpt_pkg::ROLE_CAPTURE) & aux_b_trig;

  // reload role: pin edge or chosen core latch transition [R12]
  assign rel_a_hit = (aux_a_cfg.role == gpt_pkg::ROLE_RELOAD) &
                     ((aux_a_cfg.reload_ext & aux_a_trig) |
                      (aux_a_cfg.reload_tl_rise & core_tl_rise) |
                      (aux_a_cfg.reload_tl_fall & core_tl_fall));
  assign rel_b_hit = (aux_b_cfg.role == gpt_pkg::ROLE_RELOAD) &
                     ((aux_b_cfg.reload_ext & aux_b_trig) |
                      (aux_b_cfg.reload_tl_rise & core_tl_rise) |
                      (aux_b_cfg.reload_tl_fall & core_tl_fall));

  // capture trigger: own pin or core clock/direction pin [R18] [R19]
  assign cap_ev = (cap_cfg.src_capture_trigger_input &
                   edge_hit(cap_cfg.edge_sel, pin_rise[gpt_pkg::PIN_CAP],
                            pin_fall[gpt_pkg::PIN_CAP])) |
                  (cap_cfg.src_core_clk &
                   edge_hit(cap_cfg.edge_sel,
                            pin_rise[gpt_pkg::PIN_CLK_BASE + gpt_pkg::IDX_CORE],
                            pin_fall[gpt_pkg::PIN_CLK_BASE + gpt_pkg::IDX_CORE])) |
                  (cap_cfg.src_core_dir &
                   edge_hit(cap_cfg.edge_sel,
                            pin_rise[gpt_pkg::PIN_DIR_BASE + gpt_pkg::IDX_CORE],
                            pin_fall[gpt_pkg::PIN_DIR_BASE + gpt_pkg::IDX_CORE]));

  // hardware loads into each timer
  assign load[gpt_pkg::IDX_AUX_A] = cap_a_hit;  // [R11]
  assign load_val[gpt_pkg::IDX_AUX_A] = timer_value[gpt_pkg::IDX_CORE];
  assign load[gpt_pkg::IDX_AUX_B] = cap_b_hit;  // [R11]
  assign load_val[gpt_pkg::IDX_AUX_B] = timer_value[gpt_pkg::IDX_CORE];
  // opposite latch edges alternate two reloads: PWM [R12] [R13]
  assign load[gpt_pkg::IDX_CORE] = rel_a_hit | rel_b_hit;
  assign load_val[gpt_pkg::IDX_CORE] = rel_a_hit ? timer_value[gpt_pkg::IDX_AUX_A]
                                                 : timer_value[gpt_pkg::IDX_AUX_B];
  // precision timer cleared on the same clock edge as a capture when asked [R18]
  assign load[gpt_pkg::IDX_PREC] = cap_ev & cap_cfg.clear_after;
  assign load_val[gpt_pkg::IDX_PREC] = gpt_pkg::CLEAR_VALUE;
  // secondary wrap reloads it from the capture/reload register [R17]
  assign load[gpt_pkg::IDX_SEC] = wrap[gpt_pkg::IDX_SEC] & cap_cfg.reload_sec;
  assign load_val[gpt_pkg::IDX_SEC] = cap_q;

  // free-running prescaler base shared by all timers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      presc_cnt_q <= gpt_pkg::PRESC_RST;
    end else begin
      presc_cnt_q <= 16'(presc_cnt_q + gpt_pkg::ONE);
    end
  end

  // toggle latches invert on every wrap of their timer [R8] [R16]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_tl_q <= 1'b0;
      sec_tl_q <= 1'b0;
    end else begin
      core_tl_q <= core_tl_q ^ wrap[gpt_pkg::IDX_CORE];  // [R8]
      sec_tl_q <= sec_tl_q ^ wrap[gpt_pkg::IDX_SEC];  // [R16]
    end
  end

  // capture/reload register: a capture wins over a software write [R18]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cap_q <= gpt_pkg::VALUE_RST;
    end else if (cap_ev) begin
      cap_q <= timer_value[gpt_pkg::IDX_PREC];  // [R18]
    end else if (cap_wr) begin
      cap_q <= cap_wdata;
    end
  end

  // registered pin drivers and the exported secondary wrap event
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_out_q <= 1'b0;
      sec_out_q <= 1'b0;
      sec_wrap_q <= 1'b0;
    end else begin
      core_out_q <= core_out_en & core_tl_q;  // [R8]
      sec_out_q <= sec_out_en & sec_tl_q;  // [R16]
      sec_wrap_q <= wrap[gpt_pkg::IDX_SEC];  // [R17]
    end
  end

  assign capture_reload_register = cap_q;
  assign core_toggle_latch = core_tl_q;
  assign secondary_toggle_latch = sec_tl_q;
  assign core_toggle_output = core_out_q;
  assign secondary_toggle_output = sec_out_q;
  assign secondary_wrap_event = sec_wrap_q;

endmodule

// ---- dv/ext_pins.sv ----
// far-side model: event pins and a position encoder
`timescale 1ns/1ns
module ext_pins (
  input logic clk,
  output logic [4:0] clk_pin,
  output logic [4:0] dir_pin,
  output logic cap_pin
);
  // pins in slot order: clock, direction, capture
  logic [10:0] pv = 11'h000;
  assign clk_pin = pv[4:0];
  assign dir_pin = pv[9:5];
  assign cap_pin = pv[10];
  // each level holds 4 to 9 cycles
  task automatic hold();
    repeat ($urandom_range(9, 4)) @(negedge clk);
  endtask
  // drive a pin level and hold it
  task automatic level(input int s, input logic val);
    pv[s] = val;
    hold();
  endtask
  // one full pulse, both levels held
  task automatic pulse(input int s);
    repeat (2) level(s, !pv[s]);
  endtask
  // one encoder step: phase a on clock pin, b on direction pin
  task automatic enc_step(input bit up);
    if ((pv[1] == pv[6]) == up) level(1, !pv[1]);
    else level(6, !pv[6]);
  endtask
endmodule

// ---- dv/general_timer_unit_asserts.sv ----
// port-level assertion checker for the timer unit
`timescale 1ns/1ns
module gtu_asserts (
  input logic clk,
  input logic sys_rst,
  input gpt_pkg::tmr_cfg_t [4:0] tmr_cfg,
  input gpt_pkg::aux_cfg_t aux_a_cfg,
  input gpt_pkg::aux_cfg_t aux_b_cfg,
  input gpt_pkg::cap_cfg_t cap_cfg,
  input logic [4:0] tmr_wr,
  input logic [15:0] tmr_wdata,
  input logic core_out_en,
  input logic sec_out_en,
  input logic [4:0][15:0] timer_value,
  input logic [15:0] capture_reload_register,
  input logic core_toggle_latch,
  input logic secondary_toggle_latch,
  input logic core_toggle_output,
  input logic secondary_toggle_output,
  input logic secondary_wrap_event
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // no aux role can load the core
  wire aux_plain = aux_a_cfg.role == gpt_pkg::ROLE_COUNT && aux_b_cfg.role == gpt_pkg::ROLE_COUNT;
  // core free-running at the finest prescale
  wire core_free = tmr_cfg[1].run && tmr_cfg[1].mode == gpt_pkg::MODE_TIMER
    && tmr_cfg[1].presc == 3'h0 && aux_plain && !tmr_wr[1];
  logic [15:0] core_prev_q; // core value one cycle ago
  logic [7:0] gap_q; // cycles since the core last moved
  logic [7:0] age_q; // free-running cycles, saturating
  // step spacing helpers
  always_ff @(posedge clk) begin
    core_prev_q <= timer_value[1];
    gap_q <= (timer_value[1] != core_prev_q) ? 8'h00 : gap_q + 8'h01;
    age_q <= (sys_rst || !core_free) ? 8'h00 : age_q + {7'h00, age_q != 8'hFF};
  end
  property p_core_step; $changed(timer_value[1]) && age_q > 8'h09 |-> gap_q == 8'h03; endproperty
  a_core_step: assert property (p_core_step) else $error("core step spacing wrong");
  property p_core_tl;
    $changed(core_toggle_latch) && $past(aux_plain) |->
      ($past(timer_value[1]) == 16'hFFFF && timer_value[1] == 16'h0000)
      || ($past(timer_value[1]) == 16'h0000 && timer_value[1] == 16'hFFFF);
  endproperty
  a_core_tl: assert property (p_core_tl) else $error("core latch moved without wrap");
  property p_core_out; core_toggle_output == $past(core_out_en && core_toggle_latch); endproperty
  a_core_out: assert property (p_core_out) else $error("core toggle pin wrong");
  property p_sec_out; secondary_toggle_output == $past(sec_out_en && secondary_toggle_latch);
  endproperty
  a_sec_out: assert property (p_sec_out) else $error("secondary toggle pin wrong");
  property p_sec_ev; $changed(secondary_toggle_latch) |-> ##[0:1] secondary_wrap_event; endproperty
  a_sec_ev: assert property (p_sec_ev) else $error("secondary wrap not exported");
  property p_sec_wr; tmr_wr[4] && !cap_cfg.reload_sec |=> timer_value[4] == $past(tmr_wdata);
  endproperty
  a_sec_wr: assert property (p_sec_wr) else $error("secondary write lost");
  property p_capture;
    $changed(timer_value[0]) && $past(aux_a_cfg.role) == gpt_pkg::ROLE_CAPTURE && !$past(tmr_wr[0])
      |-> timer_value[0] == $past(timer_value[1]);
  endproperty
  a_capture: assert property (p_capture) else $error("aux capture value wrong");
  property p_sec_reload;
    $changed(secondary_toggle_latch) && $past(cap_cfg.reload_sec) && !$past(tmr_wr[4])
      |-> timer_value[4] == $past(capture_reload_register);
  endproperty
  a_sec_reload: assert property (p_sec_reload) else $error("secondary reload wrong");
endmodule
bind general_timer_unit gtu_asserts chk_i (.*);

// ---- dv/general_timer_unit_tb.sv ----
// self-checking bench for the timer unit with a pin and encoder model
`timescale 1ns/1ns
module general_timer_unit_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] tcg; // clock/gate pins
  logic [4:0] tdir; // direction pins
  logic cap_in; // capture pin
  gpt_pkg::tmr_cfg_t [4:0] tmr_cfg = '0;
  gpt_pkg::aux_cfg_t aux_a_cfg = '0;
  gpt_pkg::aux_cfg_t aux_b_cfg = '0;
  gpt_pkg::cap_cfg_t cap_cfg = '0;
  logic [4:0] tmr_wr = 5'h00;
  logic [15:0] tmr_wdata = 16'h0000;
  logic cap_wr = 1'b0;
  logic [15:0] cap_wdata = 16'h0000;
  logic core_out_en = 1'b0;
  logic sec_out_en = 1'b0;
  logic [4:0][15:0] timer_value;
  logic [15:0] capture_reload_register;
  logic core_toggle_latch, secondary_toggle_latch, secondary_wrap_event;
  logic core_toggle_output, secondary_toggle_output;
  int err_total = 0;
  int checked = 0;
  int cyc = 0; // timeout counter
  int ev_n = 0; // secondary wrap pulses seen
  int ex; // encoder position model
  int n;
  logic tl = 1'b0; // core latch model
  logic [15:0] v, r;
  ext_pins pins (.clk(clk), .clk_pin(tcg), .dir_pin(tdir), .cap_pin(cap_in));
  general_timer_unit uut (.timer_clock_gate_input(tcg), .timer_direction_input(tdir),
    .capture_trigger_input(cap_in), .*);
  // 50 mhz clock
  always #10 clk = !clk;
  // count exported wrap pulses
  always @(negedge clk) if (secondary_wrap_event === 1'b1) ev_n++;
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe, then an idle edge
  task automatic wr(input int s, input logic [15:0] d);
    tmr_wr[s] = 1'b1;
    tmr_wdata = d;
    @(negedge clk);
    tmr_wr = 5'h00;
    @(negedge clk);
  endtask
  // bounded wait for a timer value
  task automatic wait_val(input int s, input logic [15:0] d);
    repeat (600) if (timer_value[s] !== d) @(negedge clk);
  endtask
  // run a timer in a mode
  task automatic cfg(input int s, input gpt_pkg::timer_mode_t m, input logic [1:0] es);
    tmr_cfg[s] = '0;
    tmr_cfg[s].run = 1'b1;
    tmr_cfg[s].mode = m;
    tmr_cfg[s].edge_sel = es;
  endtask
  task automatic summarize();
    if (err_total == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h14BE));
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk);
    // reset values, then random writes
    chk(capture_reload_register, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      chk(timer_value[i], 16'h0000);
      v = 16'($urandom);
      wr(i, v);
      chk(timer_value[i], v);
    end
    // core wraps up, then down, toggling its latch
    core_out_en = 1'b1;
    cfg(1, gpt_pkg::MODE_TIMER, 2'b00);
    wr(1, 16'hFFF0);
    wait_val(1, 16'h0000);
    chk(16'(core_toggle_latch), 16'h0001);
    @(negedge clk);
    chk(16'(core_toggle_output), 16'h0001);
    tmr_cfg[1].dir_down = 1'b1;
    wait_val(1, 16'hFFFF);
    chk(16'(core_toggle_latch), 16'h0000);
    // aux a counts pin edges, then down by its direction pin
    cfg(0, gpt_pkg::MODE_COUNTER, 2'b01);
    v = 16'($urandom);
    wr(0, v);
    n = $urandom_range(6, 1);
    repeat (n) pins.pulse(0);
    chk(timer_value[0], v + 16'(n));
    tmr_cfg[0].edge_sel = 2'b11;
    tmr_cfg[0].dir_ext_en = 1'b1;
    pins.level(gpt_pkg::PIN_DIR_BASE, 1'b1);
    repeat (n) pins.pulse(0);
    chk(timer_value[0], v - 16'(n));
    pins.level(gpt_pkg::PIN_DIR_BASE, 1'b0);
    // aux b counts only with its gate open
    cfg(2, gpt_pkg::MODE_GATED, 2'b00);
    tmr_cfg[2].gate_pol = 1'b1;
    wr(2, 16'h0000);
    repeat (40) @(negedge clk);
    chk(timer_value[2], 16'h0000);
    pins.level(2, 1'b1);
    repeat (36) @(negedge clk);
    pins.level(2, 1'b0);
    v = timer_value[2];
    chk(16'(v >= 16'h0009 && v <= 16'h000C), 16'h0001);
    // core follows a random encoder walk
    cfg(1, gpt_pkg::MODE_ENCODER, 2'b00);
    wr(1, 16'h0003);
    ex = 3;
    repeat (12) begin
      n = $urandom_range(1, 0);
      pins.enc_step(n[0]);
      if ((ex == 0 && n == 0) || (ex == -1 && n == 1)) tl = !tl;
      ex = (n == 1) ? ex + 1 : ex - 1;
      chk(timer_value[1], 16'(ex));
    end
    chk(16'(core_toggle_latch), 16'(tl));
    // aux a in capture role stops, then grabs the core
    tmr_cfg[1] = '0;
    v = 16'($urandom);
    wr(1, v);
    cfg(0, gpt_pkg::MODE_TIMER, 2'b01);
    aux_a_cfg.role = gpt_pkg::ROLE_CAPTURE;
    wr(0, 16'h5A5A);
    repeat (20) @(negedge clk);
    chk(timer_value[0], 16'h5A5A);
    pins.pulse(0);
    chk(timer_value[0], v);
    // aux b reloads the core on its pin's fall
    aux_a_cfg = '0;
    tmr_cfg[0] = '0;
    aux_b_cfg.role = gpt_pkg::ROLE_RELOAD;
    aux_b_cfg.reload_ext = 1'b1;
    tmr_cfg[2] = '0;
    tmr_cfg[2].edge_sel = 2'b10;
    r = 16'($urandom);
    wr(2, r);
    pins.pulse(2);
    chk(timer_value[1], r);
    // opposite latch edges reload alternately: pwm
    aux_a_cfg.role = gpt_pkg::ROLE_RELOAD;
    aux_a_cfg.reload_tl_rise = 1'b1;
    aux_b_cfg = '0;
    aux_b_cfg.role = gpt_pkg::ROLE_RELOAD;
    aux_b_cfg.reload_tl_fall = 1'b1;
    tmr_cfg[2] = '0;
    wr(0, 16'hFFF8);
    wr(2, 16'hFFFC);
    wr(1, 16'hFFFE);
    cfg(1, gpt_pkg::MODE_TIMER, 2'b00);
    repeat (4) begin
      tl = !tl;
      repeat (600) if (core_toggle_latch !== tl) @(negedge clk);
      chk(timer_value[1], tl ? 16'hFFF8 : 16'hFFFC);
    end
    tmr_cfg[1] = '0;
    aux_a_cfg = '0;
    aux_b_cfg = '0;
    // capture sources: own pin with clear, core clock pin, core direction pin
    for (int k = 0; k < 3; k++) begin
      cap_cfg = {2'b01, k == 0, k == 1, k == 2, k == 0, 1'b0};
      v = 16'($urandom);
      wr(3, v);
      pins.pulse(k == 0 ? 10 : (k == 1 ? 1 : 6));
      chk(capture_reload_register, v);
      chk(timer_value[3], k == 0 ? 16'h0000 : v);
    end
    // secondary wrap reloads, exports a pulse, clocks the precision timer
    cap_cfg = '0;
    cap_cfg.reload_sec = 1'b1;
    r = 16'($urandom) & 16'h7FFF;
    cap_wdata = r;
    cap_wr = 1'b1;
    @(negedge clk);
    cap_wr = 1'b0;
    cfg(3, gpt_pkg::MODE_COUNTER, 2'b11);
    tmr_cfg[3].clk_tl = 1'b1;
    wr(3, 16'h0000);
    sec_out_en = 1'b1;
    ex = ev_n;
    cfg(4, gpt_pkg::MODE_TIMER, 2'b00);
    wr(4, 16'hFFFE);
    repeat (600) if (secondary_toggle_latch !== 1'b1) @(negedge clk);
    chk(timer_value[4], r);
    repeat (3) @(negedge clk);
    chk(16'(secondary_toggle_output), 16'h0001);
    chk(timer_value[3], 16'h0001);
    chk(16'(ev_n - ex), 16'h0001);
    summarize();
  end
endmodule
